// file: src/ppmi_pkg.sv
package ppmi_pkg;
	localparam int PORT_W = 8;
	localparam logic [31:0] IDX_MASK = 32'h0000_0086;
	localparam logic [31:0] IDX_PATN = 32'h0000_0093;
	localparam logic [31:0] IDX_CTRL = 32'h0000_0094;
	localparam logic [31:0] OFS_MASK = IDX_MASK * 4;
	localparam logic [31:0] OFS_PATN = IDX_PATN * 4;
	localparam logic [31:0] OFS_CTRL = IDX_CTRL * 4;
	localparam logic [31:0] OFS_IEN = 32'h0000_0200;
	localparam logic [31:0] OFS_ISTAT = 32'h0000_0204;
	localparam logic [31:0] OFS_ICLR = 32'h0000_0208;
	localparam logic [31:0] OFS_IEN_STATUS = 32'h0000_020C;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] PATN_RST = 8'hFF;
	localparam int CTRL_FLAG_BIT = 0;
	localparam int CTRL_POL_BIT = 1;
	localparam int IEN_MATCH_BIT = 0;
	localparam int IEN_GLOBAL_BIT = 1;
	localparam int HOLD_CYCLES = 6;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// file: src/ppmi_bus_if.sv
`timescale 1ns/1ps
interface ppmi_bus_if;
	logic wr;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport master (output wr, output addr, output wdata, input rdata);
	modport slave (input wr, input addr, input wdata, output rdata);
endinterface

// file: src/ppmi_regs.sv
`timescale 1ns/1ps
module ppmi_regs (
	input wire logic mclk,
	input wire logic rst,
	ppmi_bus_if.slave bus,
	input wire logic match_set,
	output logic [7:0] pin_trigger_mask_r,
	output logic [7:0] match_pattern_r,
	output logic match_polarity_select_r,
	output logic match_flag_r,
	output logic [1:0] irq_en_r
);
	// Events hold the bit until software writes zero to control or one to the clear register; a same-cycle set wins.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_trigger_mask_r <= ppmi_pkg::MASK_RST;
			match_pattern_r <= ppmi_pkg::PATN_RST;
			match_polarity_select_r <= 1'b0;
			irq_en_r <= 2'h0;
		end else if (bus.wr) begin
			if (bus.addr == ppmi_pkg::OFS_MASK) pin_trigger_mask_r <= bus.wdata[7:0];
			if (bus.addr == ppmi_pkg::OFS_PATN) match_pattern_r <= bus.wdata[7:0];
			if (bus.addr == ppmi_pkg::OFS_CTRL) match_polarity_select_r <= bus.wdata[ppmi_pkg::CTRL_POL_BIT];
			if (bus.addr == ppmi_pkg::OFS_IEN) irq_en_r <= bus.wdata[1:0];
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			match_flag_r <= 1'b0;
		end else if (match_set) begin
			match_flag_r <= 1'b1;
		end else if (bus.wr && bus.addr == ppmi_pkg::OFS_CTRL && !bus.wdata[ppmi_pkg::CTRL_FLAG_BIT]) begin
			match_flag_r <= 1'b0;
		end else if (bus.wr && bus.addr == ppmi_pkg::OFS_ICLR && bus.wdata[0]) begin
			match_flag_r <= 1'b0;
		end
	end
	always_comb begin
		case (bus.addr)
			ppmi_pkg::OFS_MASK: bus.rdata = {24'h000000, pin_trigger_mask_r};
			ppmi_pkg::OFS_PATN: bus.rdata = {24'h000000, match_pattern_r};
			ppmi_pkg::OFS_CTRL: bus.rdata = {30'h00000000, match_polarity_select_r, match_flag_r};
			ppmi_pkg::OFS_IEN: bus.rdata = {30'h00000000, irq_en_r};
			ppmi_pkg::OFS_ISTAT: bus.rdata = {31'h00000000, match_flag_r};
			default: bus.rdata = 32'h00000000;
		endcase
	end
endmodule

// file: src/ppmi_top.sv
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
// Functional notes
// - A pin takes part in the match only when its mask bit is set.
// - The live port value is compared with the pattern register.
// - Polarity bit one selects equal as match, zero selects not equal.
// - The flag is set once the selected condition has held past the filter time while the function is active.
// - The flag is never cleared by hardware; software writes zero to clear it.
// - The interrupt is raised only while flag, match enable and global enable are all set.
// - The flag is set only after the condition has lasted more than six clocks.
// - The interrupt output also serves as wake request from idle and power down.
// - The pattern register is read and write over eight bits and resets to all ones.
// - The mask resets to zero so nothing matches before setup.
// - The mask acts only while the function is enabled.
// - Control holds polarity in bit one and flag in bit zero, both reset to zero.
module ppmi_top #(
	parameter int HOLD = ppmi_pkg::HOLD_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] watched_port_pin,
	output logic pattern_match_interrupt,
	output logic wake_request
);
	// ==========================================
	// Local types, widths and helpers

	// The hold counter must be able to reach HOLD and still have room to saturate.
	localparam int HOLD_W = $clog2(HOLD + 2);

	// Tracks which data phase the bus is in.
	// A read gets one wait cycle, so that a write whose data phase ends at its address edge lands first.
	typedef enum logic [1:0] {
		PPMI_BUS_IDLE,
		PPMI_BUS_WRITE,
		PPMI_BUS_RD_WAIT,
		PPMI_BUS_RD_DATA
	} ppmi_bus_st_t;

	// An address phase is taken only for a whole-word single transfer while the bus is ready.
	function automatic logic ppmi_take(
		input logic sel,
		input logic [1:0] trans,
		input logic [2:0] size,
		input logic rdy
	);
		ppmi_take = sel && trans == ppmi_pkg::HTRANS_NONSEQ && size == ppmi_pkg::HSIZE_WORD && rdy;
	endfunction

	// A pin agrees with the pattern when it is masked out or when its level equals the pattern bit.
	function automatic logic ppmi_pin_hit(
		input logic mask_bit,
		input logic pin_bit,
		input logic patn_bit
	);
		ppmi_pin_hit = !mask_bit || (pin_bit == patn_bit);
	endfunction

	// ==========================================
	// Declarations

	ppmi_bus_if bus ();
	ppmi_bus_st_t bus_st_r;
	ppmi_bus_st_t bus_st_nxt;
	logic take_wr;
	logic take_rd;
	logic [31:0] ph_addr_r;
	logic [7:0] mask;
	logic [7:0] patn;
	logic pol;
	logic flag;
	logic [1:0] ien;
	logic [7:0] pin_hit;
	logic all_equal;
	logic active;
	logic cond;
	logic [HOLD_W-1:0] hold_r;
	logic hold_done;
	logic match_set;

	// ==========================================
	// Bus slave: address phase decode

	assign take_wr = ppmi_take(hsel, htrans, hsize, hready) && hwrite;
	assign take_rd = ppmi_take(hsel, htrans, hsize, hready) && !hwrite;

	always_comb begin
		bus_st_nxt = bus_st_r;
		case (bus_st_r)
			PPMI_BUS_RD_WAIT: begin
				bus_st_nxt = PPMI_BUS_RD_DATA;
			end
			PPMI_BUS_IDLE, PPMI_BUS_WRITE, PPMI_BUS_RD_DATA: begin
				if (take_wr) begin
					bus_st_nxt = PPMI_BUS_WRITE;
				end else if (take_rd) begin
					bus_st_nxt = PPMI_BUS_RD_WAIT;
				end else if (hready) begin
					bus_st_nxt = PPMI_BUS_IDLE;
				end
			end
			default: begin
				bus_st_nxt = PPMI_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bus_st_r <= PPMI_BUS_IDLE;
		end else begin
			bus_st_r <= bus_st_nxt;
		end
	end

	// The address of a taken phase stands through its whole data phase, wait cycle included.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ph_addr_r <= 32'h00000000;
		end else if (take_wr || take_rd) begin
			ph_addr_r <= haddr;
		end
	end

	// ==========================================
	// Bus slave: data phase

	assign hreadyout = bus_st_r != PPMI_BUS_RD_WAIT;
	assign hresp = 1'h0;

	// A write commits at the edge that closes its data phase.
	assign bus.wr = bus_st_r == PPMI_BUS_WRITE && hready;
	assign bus.addr = ph_addr_r;
	assign bus.wdata = hwdata;

	// Read data is captured at the end of the wait cycle and stands until the next read.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (bus_st_r == PPMI_BUS_RD_WAIT) begin
			hrdata <= bus.rdata;
		end
	end

	// ==========================================
	// Register bank

	ppmi_regs u_regs (
		.mclk(mclk),
		.rst(rst),
		.bus(bus.slave),
		.match_set(match_set),
		.pin_trigger_mask_r(mask),
		.match_pattern_r(patn),
		.match_polarity_select_r(pol),
		.match_flag_r(flag),
		.irq_en_r(ien)
	);

	// ==========================================
	// Match detection

	// Each pin is judged on its own; a masked-out pin always agrees.
	generate
		for (genvar gi = 0; gi < 8; gi++) begin : g_pin
			assign pin_hit[gi] = ppmi_pin_hit(mask[gi], watched_port_pin[gi], patn[gi]);
		end
	endgenerate

	assign all_equal = &pin_hit;

	// The function counts as active while the match interrupt enable is set.
	assign active = ien[ppmi_pkg::IEN_MATCH_BIT];

	always_comb begin
		cond = 1'h0;
		if (active) begin
			if (pol) begin
				cond = all_equal;
			end else begin
				cond = !all_equal;
			end
		end
	end

	// ==========================================
	// Persistence filter

	// Counts cycles in which the condition has held; any drop restarts the count.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hold_r <= '0;
		end else if (!cond) begin
			hold_r <= '0;
		end else if (!hold_done) begin
			hold_r <= hold_r + 1'h1;
		end
	end

	// The flag sets in the cycle after the condition has held more than HOLD cycles.
	assign hold_done = hold_r >= HOLD_W'(HOLD);
	assign match_set = cond && hold_done;

	// ==========================================
	// Interrupt

	assign pattern_match_interrupt = flag && ien[ppmi_pkg::IEN_MATCH_BIT] && ien[ppmi_pkg::IEN_GLOBAL_BIT];

	// The same level serves as wake request, so it needs no clock edge to be seen.
	assign wake_request = pattern_match_interrupt;

	// ==========================================
	// Assertions

	sequence s_held_long;
		cond [*7];
	endsequence

	sequence s_flag_next;
		##1 flag;
	endsequence

	sequence s_wait_then_ready;
		!hreadyout ##1 hreadyout;
	endsequence

	a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
		$fell(flag) |-> $past(bus.wr))
		else $error("flag fell without write");

	a_flag_holds: assert property (@(posedge mclk) disable iff (rst)
		flag && !bus.wr |=> flag)
		else $error("flag dropped on its own");

	a_hold_time: assert property (@(posedge mclk) disable iff (rst)
		$rose(flag) |-> $past(cond, 7))
		else $error("flag set too soon");

	a_held_sets: assert property (@(posedge mclk) disable iff (rst)
		s_held_long |-> s_flag_next)
		else $error("flag missed after long match");

	a_idle_no_flag: assert property (@(posedge mclk) disable iff (rst)
		!active && !flag |=> !flag)
		else $error("flag set while inactive");

	a_irq_gate: assert property (@(posedge mclk) disable iff (rst)
		pattern_match_interrupt |-> flag && ien == 2'h3)
		else $error("irq without enables");

	a_mask_rst: assert property (@(posedge mclk)
		$fell(rst) |-> mask == ppmi_pkg::MASK_RST && patn == ppmi_pkg::PATN_RST && !pol && !flag)
		else $error("registers not at reset values");

	a_read_wait: assert property (@(posedge mclk) disable iff (rst)
		bus_st_r == PPMI_BUS_RD_WAIT |-> s_wait_then_ready)
		else $error("read wait cycle wrong");
endmodule

// file: verification/ppmi_keypad.sv
`timescale 1ns/1ps
// A pressed key pulls its line low; a released line rests high on its pull-up.
module ppmi_keypad (
	input wire logic [7:0] keys,
	output logic [7:0] watched_port_pin
);
	assign watched_port_pin = ~keys;
endmodule

// file: verification/port_pattern_match_interrupt_tb.sv
`timescale 1ns/1ps
module port_pattern_match_interrupt_tb;
	logic mclk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq, wake;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [7:0] keys = 8'h00, pins;
	int error_cnt = 0, num_checks = 0;
	always #5 mclk = ~mclk;
	assign hready = hreadyout;
	ppmi_keypad u_keys (.keys(keys), .watched_port_pin(pins));
	ppmi_top u_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.watched_port_pin(pins), .pattern_match_interrupt(irq), .wake_request(wake));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// The master holds each phase until hready is seen high, within a bound.
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge mclk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 50) begin
				error_cnt++;
				complete_run();
			end
			@(posedge mclk);
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= ppmi_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
		@(posedge mclk);
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [7:0] e, input string what);
		xfer(1'b0, a, 32'h0);
		chk(what, rd[7:0], e);
	endtask
	task automatic ctl(input logic [7:0] e, input string what);
		xfer(1'b0, ppmi_pkg::OFS_CTRL, 32'h0);
		chk(what, rd[7:0] & 8'h03, e);
	endtask
	task automatic press(input logic [7:0] k, input int n);
		keys <= k;
		repeat (n) @(posedge mclk);
		keys <= 8'h00;
		repeat (4) @(posedge mclk);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rdchk(ppmi_pkg::OFS_MASK, 8'h00, "mask reset");
		rdchk(ppmi_pkg::OFS_PATN, 8'hFF, "pattern reset");
		ctl(8'h00, "control reset");
		xfer(1'b1, ppmi_pkg::OFS_PATN, 32'h0000_00A5);
		rdchk(ppmi_pkg::OFS_PATN, 8'hA5, "pattern rw");
		xfer(1'b1, ppmi_pkg::OFS_PATN, 32'h0000_00FF);
		xfer(1'b1, ppmi_pkg::OFS_MASK, 32'h0000_0081);
		xfer(1'b1, ppmi_pkg::OFS_IEN, 32'h0000_0003);
		press(8'h01, 6);
		ctl(8'h00, "short press");
		press(8'h02, 20);
		ctl(8'h00, "masked pin");
		press(8'h80, 7);
		ctl(8'h01, "flag set");
		chk("irq and wake", {6'h0, wake, irq}, 8'h03);
		xfer(1'b1, ppmi_pkg::OFS_IEN, 32'h0000_0001);
		chk("irq global off", {7'h0, irq}, 8'h00);
		ctl(8'h01, "flag sticky");
		xfer(1'b1, ppmi_pkg::OFS_CTRL, 32'h0000_0000);
		ctl(8'h00, "flag cleared");
		$display("any-key test done");
		xfer(1'b1, ppmi_pkg::OFS_IEN, 32'h0000_0000);
		xfer(1'b1, ppmi_pkg::OFS_CTRL, 32'h0000_0002);
		repeat (10) @(posedge mclk);
		ctl(8'h02, "inactive no flag");
		xfer(1'b1, ppmi_pkg::OFS_PATN, 32'h0000_005A);
		xfer(1'b1, ppmi_pkg::OFS_MASK, 32'h0000_00BF);
		xfer(1'b1, ppmi_pkg::OFS_IEN, 32'h0000_0001);
		ctl(8'h02, "equal idle");
		press(8'hA5, 10);
		ctl(8'h03, "equal match");
		rdchk(ppmi_pkg::OFS_ISTAT, 8'h01, "status flag");
		chk("okay response", {7'h0, hresp}, 8'h00);
		xfer(1'b1, ppmi_pkg::OFS_ICLR, 32'h0000_0001);
		ctl(8'h02, "clear register");
		$display("equal test done");
		xfer(1'b1, ppmi_pkg::OFS_PATN, 32'h0000_0033);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rdchk(ppmi_pkg::OFS_PATN, 8'hFF, "pattern rereset");
		rdchk(ppmi_pkg::OFS_MASK, 8'h00, "mask rereset");
		ctl(8'h00, "control rereset");
		$display("reset test done");
		complete_run();
	end
endmodule
